//--- hdl/ldc_drive_control.sv
// Purpose: Control logic of a segment LCD controller/driver
// Assumes: Frame source ticks are one-cycle pulses synchronous to mclk
// Notes:   Analog rails are outside; outputs name the rail each pin takes
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
module ldc_drive_control (
	// Clock and reset
	input  wire logic                        mclk,
	input  wire logic                        sys_rst,
	// Register port
	input  wire ldc_pkg::ldc_bus_t           bus_req,
	output logic [7:0]                       rd_data,
	// Frame sources and standby
	input  wire logic                        timebase_tick,
	input  wire logic                        subclock_tick,
	input  wire logic                        watch_mode_flag,
	// Panel drive
	output ldc_pkg::ldc_lvl_t [3:0]          common_drive_outputs,
	output ldc_pkg::ldc_lvl_t [23:0]         segment_drive_outputs,
	output logic                             booster_cap_a,
	output logic                             booster_cap_b,
	output logic [3:0]                       drive_supply_pins,
	// Supply path control
	output logic                             divider_path_close,
	output logic                             ref_gen_disconnect,
	output logic                             panel_enable
);

	// ==========================================================
	// Decoding helpers
	function automatic logic is_ram(input logic [7:0] a);
		is_ram = (a[7:4] == ldc_pkg::RAM_PAGE) && (a[3:0] <= ldc_pkg::RAM_LAST_LO);
	endfunction

	function automatic ldc_pkg::ldc_lvl_t com_level(input logic sel, input logic ph, input logic b3);
		if (sel) begin
			com_level = ph ? ldc_pkg::LVL_V0 : ldc_pkg::LVL_V3;
		end else if (b3) begin
			com_level = ph ? ldc_pkg::LVL_V2 : ldc_pkg::LVL_V1;
		end else begin
			com_level = ldc_pkg::LVL_V1;
		end
	endfunction

	function automatic ldc_pkg::ldc_lvl_t seg_level(input logic on, input logic ph, input logic b3);
		if (on) begin
			seg_level = ph ? ldc_pkg::LVL_V3 : ldc_pkg::LVL_V0;
		end else if (b3) begin
			seg_level = ph ? ldc_pkg::LVL_V1 : ldc_pkg::LVL_V2;
		end else begin
			seg_level = ph ? ldc_pkg::LVL_V0 : ldc_pkg::LVL_V3;
		end
	endfunction

	// ==========================================================
	// State
	ldc_pkg::ldc_ctrl_t        ctrl_r, ctrl_nxt, wr_view;
	logic [3:0]                ram_r [ldc_pkg::NUM_SEG];
	logic [3:0]                ram_nxt [ldc_pkg::NUM_SEG];
	logic [7:0]                rdata_r, rdata_nxt;
	ldc_pkg::ldc_state_t       state_r, state_nxt;
	logic [3:0]                div_r, div_nxt, div_last;
	logic [1:0]                slot_r, slot_nxt, mode;
	logic                      phase_r, phase_nxt;
	ldc_pkg::ldc_lvl_t [3:0]   com_r, com_nxt;
	ldc_pkg::ldc_lvl_t [23:0]  seg_r, seg_nxt;
	logic                      cap_a_r, cap_a_nxt, cap_b_r, cap_b_nxt;
	logic [3:0]                sup_r, sup_nxt;
	logic [4:0]                ram_lo_idx;
	logic                      src_tick, active_req, run_now, bias3;
	ldc_pkg::ldc_lvl_t         seg_desel, seg_sel, com_desel;

	assign wr_view    = bus_req.wdata;
	assign ram_lo_idx = {bus_req.addr[3:0], 1'b0};
	assign mode       = {ctrl_r.display_mode_hi, ctrl_r.display_mode_lo};
	assign div_last   = ldc_pkg::SLOT_TICKS[{ctrl_r.frame_period_hi, ctrl_r.frame_period_lo} * 4 +: 4];
	// Timebase tick is taken raw, never through the CPU speed shift
	assign src_tick   = ctrl_r.frame_clock_source ? subclock_tick : timebase_tick;
	assign active_req = (mode != ldc_pkg::MODE_STOP) && !(watch_mode_flag && !ctrl_r.watch_mode_run);
	assign run_now    = (state_r == ldc_pkg::ST_RUN) && active_req;
	assign bias3      = (mode != ldc_pkg::MODE_HALF);
	assign seg_desel  = seg_level(1'b0, phase_r, bias3);
	assign seg_sel    = seg_level(1'b1, phase_r, bias3);
	assign com_desel  = com_level(1'b0, phase_r, bias3);

	// ==========================================================
	// Register port
	always_comb begin
		ctrl_nxt  = ctrl_r;
		ram_nxt   = ram_r;
		rdata_nxt = ldc_pkg::READ_ZERO;
		if (bus_req.wr) begin
			if (bus_req.addr == ldc_pkg::CTRL_ADDR) begin
				ctrl_nxt = wr_view;
			end else if (is_ram(bus_req.addr)) begin
				ram_nxt[ram_lo_idx]      = bus_req.wdata[3:0];
				ram_nxt[ram_lo_idx + 1]  = bus_req.wdata[7:4];
			end
		end
		if (bus_req.rd) begin
			if (bus_req.addr == ldc_pkg::CTRL_ADDR) begin
				rdata_nxt = ctrl_r;
			end else if (is_ram(bus_req.addr)) begin
				rdata_nxt = {ram_r[ram_lo_idx + 1], ram_r[ram_lo_idx]};
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ctrl_r  <= ldc_pkg::CTRL_RESET;
			rdata_r <= ldc_pkg::READ_ZERO;
			for (int i = 0; i < ldc_pkg::NUM_SEG; i++) begin
				ram_r[i] <= 4'h0;
			end
		end else begin
			ctrl_r  <= ctrl_nxt;
			rdata_r <= rdata_nxt;
			ram_r   <= ram_nxt;
		end
	end

	assign rd_data = rdata_r;

	// ==========================================================
	// Slot timing and a.c. phase
	always_comb begin
		state_nxt = state_r;
		div_nxt   = div_r;
		slot_nxt  = slot_r;
		phase_nxt = phase_r;
		case (state_r)
			ldc_pkg::ST_OFF: begin
				div_nxt   = 4'h0;
				slot_nxt  = 2'h0;
				phase_nxt = 1'b0;
				if (active_req) begin
					state_nxt = ldc_pkg::ST_RUN;
				end
			end
			ldc_pkg::ST_RUN: begin
				if (!active_req) begin
					state_nxt = ldc_pkg::ST_OFF;
				end else if (src_tick) begin
					if (div_r >= div_last - 4'h1) begin
						div_nxt = 4'h0;
						// Slot count is mode plus one; >= recovers after a mode cut
						if (slot_r >= mode) begin
							slot_nxt  = 2'h0;
							phase_nxt = !phase_r;
						end else begin
							slot_nxt = slot_r + 2'h1;
						end
					end else begin
						div_nxt = div_r + 4'h1;
					end
				end
			end
			default: begin
				state_nxt = ldc_pkg::ST_OFF;
			end
		endcase
	end

	// ==========================================================
	// Pin levels
	always_comb begin
		com_nxt   = '0;
		seg_nxt   = '0;
		cap_a_nxt = 1'b0;
		cap_b_nxt = 1'b0;
		sup_nxt   = 4'h0;
		if (run_now) begin
			for (int i = 0; i < ldc_pkg::NUM_COM; i++) begin
				// Commons past the duty show deselect, even while a cut slot wraps
				com_nxt[i] = com_level((slot_r == 2'(i)) && (2'(i) <= mode), phase_r, bias3);
			end
			for (int j = 0; j < ldc_pkg::NUM_SEG; j++) begin
				seg_nxt[j] = seg_level(ram_r[j][slot_r] && !ctrl_r.blank_display, phase_r, bias3);
			end
			sup_nxt = 4'hf;
			// Booster pump runs off the subclock, two opposite phases
			cap_a_nxt = subclock_tick ? !cap_a_r : cap_a_r;
			cap_b_nxt = !cap_a_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_r <= ldc_pkg::ST_OFF;
			div_r   <= 4'h0;
			slot_r  <= 2'h0;
			phase_r <= 1'b0;
			com_r   <= '0;
			seg_r   <= '0;
			cap_a_r <= 1'b0;
			cap_b_r <= 1'b0;
			sup_r   <= 4'h0;
		end else begin
			state_r <= state_nxt;
			div_r   <= div_nxt;
			slot_r  <= slot_nxt;
			phase_r <= phase_nxt;
			com_r   <= com_nxt;
			seg_r   <= seg_nxt;
			cap_a_r <= cap_a_nxt;
			cap_b_r <= cap_b_nxt;
			sup_r   <= sup_nxt;
		end
	end

	assign common_drive_outputs  = com_r;
	assign segment_drive_outputs = seg_r;
	assign booster_cap_a         = cap_a_r;
	assign booster_cap_b         = cap_b_r;
	assign drive_supply_pins     = sup_r;
	assign divider_path_close    = ctrl_r.drive_voltage_select;
	assign ref_gen_disconnect    = ctrl_r.drive_voltage_select;
	assign panel_enable          = (state_r == ldc_pkg::ST_RUN);

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	AST_STOP_LOW: assert property ((mode == ldc_pkg::MODE_STOP) |=> (com_r == '0) && (seg_r == '0))
		else $error("outputs not low while stopped");
	AST_WATCH_STOP: assert property ((watch_mode_flag && !ctrl_r.watch_mode_run) |=> ##[0:1] (seg_r == '0))
		else $error("display ran in watch mode");
	AST_BLANK: assert property ((run_now && ctrl_r.blank_display) |=> (seg_r == {24{$past(seg_desel)}}))
		else $error("blanked segment not deselect");
	AST_HALF_COMS: assert property ((run_now && mode == ldc_pkg::MODE_HALF) |=>
		(com_r[3] == $past(com_desel)) && (com_r[2] == $past(com_desel)))
		else $error("unused common not deselect in half duty");
	AST_THIRD_COM: assert property ((run_now && mode == ldc_pkg::MODE_THIRD) |=> (com_r[3] == $past(com_desel)))
		else $error("common three not deselect in third duty");
	AST_WRAP: assert property ((run_now && src_tick && div_r >= div_last - 4'h1 && slot_r >= mode) |=>
		(slot_r == 2'h0) && (phase_r != $past(phase_r)))
		else $error("slot wrap or phase flip missing");
	AST_SRC_IDLE: assert property ((run_now && ctrl_r.frame_clock_source && !subclock_tick) |=> $stable(div_r))
		else $error("timing moved without subclock tick");
	AST_SEG_SEL: assert property ((run_now && !ctrl_r.blank_display && ram_r[0][slot_r]) |=> (seg_r[0] == $past(seg_sel)))
		else $error("set bit did not select segment");
	AST_RAM_WR: assert property ((bus_req.wr && is_ram(bus_req.addr)) |=> (ram_r[$past(ram_lo_idx)] == $past(bus_req.wdata[3:0])))
		else $error("display memory write lost");
	AST_CTRL_WR: assert property ((bus_req.wr && bus_req.addr == ldc_pkg::CTRL_ADDR) |=>
		(ctrl_r == $past(wr_view)) && (divider_path_close == $past(wr_view.drive_voltage_select)))
		else $error("control write not applied");
	AST_CTRL_RD: assert property ((bus_req.rd && bus_req.addr == ldc_pkg::CTRL_ADDR) |=> (rd_data == $past(ctrl_r)))
		else $error("control readback wrong");
	AST_RD_IDLE: assert property (!bus_req.rd |=>
		(rd_data == ldc_pkg::READ_ZERO))
		else $error("read data not zero outside read answer");
	AST_RAM_HI: assert property ((bus_req.wr && is_ram(bus_req.addr)) |=>
		(ram_r[$past(ram_lo_idx) + 1] == $past(bus_req.wdata[7:4])))
		else $error("display memory high nibble write lost");
	AST_RAM_RD: assert property ((bus_req.rd && !bus_req.wr && is_ram(bus_req.addr)) |=>
		(rd_data[3:0] == ram_r[$past(ram_lo_idx)]))
		else $error("display memory readback wrong");
	AST_SUPPLY: assert property (run_now |=>
		(drive_supply_pins == 4'hf))
		else $error("supply pins not driven while running");
	AST_CAP_PHASE: assert property (run_now |=>
		(booster_cap_b == !booster_cap_a))
		else $error("booster phases not opposite");
	AST_CAP_IDLE: assert property (!run_now |=>
		!booster_cap_a && !booster_cap_b && (drive_supply_pins == 4'h0))
		else $error("booster or supply active while stopped");
	AST_OFF_CLEAR: assert property (!active_req |=>
		!panel_enable)
		else $error("panel still enabled after stop");
	AST_OFF_RESET: assert property ((state_r == ldc_pkg::ST_OFF) |=>
		(slot_r == 2'h0) && (div_r == 4'h0) && !phase_r)
		else $error("timing not cleared while off");
	AST_START: assert property ((state_r == ldc_pkg::ST_OFF && active_req) |=>
		panel_enable)
		else $error("display did not start");
	AST_WATCH_RUN: assert property ((state_r == ldc_pkg::ST_RUN && active_req && watch_mode_flag) |=>
		panel_enable)
		else $error("display stopped in watch mode with run bit set");
	AST_SLOT_STEP: assert property ((run_now && src_tick && div_r >= div_last - 4'h1 && slot_r < mode) |=>
		(slot_r == $past(slot_r) + 2'h1) && $stable(phase_r))
		else $error("slot did not step");
	AST_DIV_STEP: assert property ((run_now && src_tick && div_r < div_last - 4'h1) |=>
		(div_r == $past(div_r) + 4'h1) && $stable(slot_r))
		else $error("slot divider did not count");
	AST_TB_IDLE: assert property ((run_now && !ctrl_r.frame_clock_source && !timebase_tick) |=>
		$stable(div_r) && $stable(slot_r))
		else $error("timing moved without timebase tick");
	AST_COM_SCAN: assert property ((run_now && slot_r == 2'h0) |=>
		(com_r[0] != $past(com_desel)))
		else $error("common zero not selected in its slot");
	AST_SEG_DESEL: assert property ((run_now && !ram_r[0][slot_r]) |=>
		(seg_r[0] == $past(seg_desel)))
		else $error("clear bit did not deselect segment");
	AST_HALF_LEVEL: assert property ((run_now && mode == ldc_pkg::MODE_HALF) |=>
		(com_r[3] == ldc_pkg::LVL_V1))
		else $error("half bias deselect level wrong");

	COV_QUARTER_WRAP: cover property (run_now && mode == ldc_pkg::MODE_QUARTER && slot_r == 2'h3 ##1 slot_r == 2'h0);
	COV_BLANK_RUN: cover property (run_now && ctrl_r.blank_display);
	COV_WATCH_RUN: cover property (run_now && watch_mode_flag);
	COV_HALF_RUN: cover property (run_now && mode == ldc_pkg::MODE_HALF);
	COV_THIRD_RUN: cover property (run_now && mode == ldc_pkg::MODE_THIRD);

endmodule // ldc_drive_control

//--- hdl/ldc_pkg.sv
// Purpose: Shared constants and types for the segment LCD drive control block
// Assumes: Byte-wide register port, frame ticks arrive as one-cycle pulses
// Notes:   Pin levels are 2-bit codes naming the drive supply rail V0..V3
// Contract
// - Four commons, 24 segments, booster and supply pins
// - Display memory of 24 four-bit entries
// - Mode field stops or selects 1/2, 1/3, 1/4 duty
// - Blank bit forces deselect on all segments
// - Source bit picks timebase tick or subclock
// - Watch-run bit keeps display alive in watch mode
// - Timebase frame timing ignores CPU speed shift
// - Drive select bit closes internal divider path
// - Drive select bit disconnects internal reference generator
// - Frame period field picks one of four cycles
// - Stopped or in reset, all panel, booster, supply and enable outputs low
// - Unused commons show deselect in 1/2, 1/3 duty
// - Memory scanned per slot, one selects, zero deselects
package ldc_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] CTRL_ADDR   = 8'h72;
	localparam logic [7:0] CTRL_RESET  = 8'h10;
	localparam logic [3:0] RAM_PAGE    = 4'h6;
	localparam logic [3:0] RAM_LAST_LO = 4'hb;
	localparam logic [7:0] READ_ZERO   = 8'h00;

	// ==========================================================
	// Geometry and modes
	localparam int         NUM_COM      = 4;
	localparam int         NUM_SEG      = 24;
	localparam logic [1:0] MODE_STOP    = 2'h0;
	localparam logic [1:0] MODE_HALF    = 2'h1;
	localparam logic [1:0] MODE_THIRD   = 2'h2;
	localparam logic [1:0] MODE_QUARTER = 2'h3;

	// Source ticks per time slot, indexed by frame period field
	localparam logic [15:0] SLOT_TICKS = {4'h8, 4'h4, 4'h2, 4'h1};

	// ==========================================================
	// Types
	typedef logic [1:0] ldc_lvl_t;
	localparam ldc_lvl_t LVL_V0 = 2'h0;
	localparam ldc_lvl_t LVL_V1 = 2'h1;
	localparam ldc_lvl_t LVL_V2 = 2'h2;
	localparam ldc_lvl_t LVL_V3 = 2'h3;

	typedef struct packed {
		logic frame_clock_source;
		logic watch_mode_run;
		logic drive_voltage_select;
		logic blank_display;
		logic display_mode_hi;
		logic display_mode_lo;
		logic frame_period_hi;
		logic frame_period_lo;
	} ldc_ctrl_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ldc_bus_t;

	typedef enum logic [1:0] {
		ST_OFF = 2'b01,
		ST_RUN = 2'b10
	} ldc_state_t;

endpackage

//--- verif/ldc_panel_model.sv
// Purpose: Glass model on the panel pins, marks cells seeing full swing
// Assumes: Rail codes follow the package encoding
// Notes:   Partial bias levels read dark, as on real glass
`timescale 1ns/100ps
module ldc_panel_model (
	// Panel pins
	input  wire ldc_pkg::ldc_lvl_t [3:0]  com,
	input  wire ldc_pkg::ldc_lvl_t [23:0] seg,
	// Lit cells, index seg*4+com
	output logic [95:0]                   lit
);
	// Shared pins reach the glass only while their port drivers sit parked off
	localparam logic [1:0]  PORT7_OUTPUT_DATA  = 2'h3;
	localparam logic [15:0] PORT64_OUTPUT_DATA = 16'hffff;

	always_comb begin
		for (int s = 0; s < 24; s++) begin
			for (int c = 0; c < 4; c++) begin
				lit[s*4+c] = ((com[c] == ldc_pkg::LVL_V3 && seg[s] == ldc_pkg::LVL_V0) ||
					(com[c] == ldc_pkg::LVL_V0 && seg[s] == ldc_pkg::LVL_V3)) &&
					(c < 2 || &PORT7_OUTPUT_DATA) && (s < 8 || &PORT64_OUTPUT_DATA);
			end
		end
	end
endmodule // ldc_panel_model

//--- verif/tb_ldc_drive_control.sv
// Purpose: Self-checking bench for the LCD drive control block
// Assumes: Pins update two edges after a sampled source tick
// Notes:   Slot and phase are reckoned from the tick count alone
`timescale 1ns/100ps
module tb_ldc_drive_control;
	logic                     mclk = 1'b0;
	logic                     sys_rst = 1'b1;
	ldc_pkg::ldc_bus_t        bus_req = '0;
	logic                     tb_tick = 1'b0;
	logic                     sc_tick = 1'b0;
	logic                     watch_mode_flag = 1'b0;
	logic [7:0]               rd_data;
	ldc_pkg::ldc_lvl_t [3:0]  com;
	ldc_pkg::ldc_lvl_t [23:0] seg;
	logic                     div_close, ref_disc, panel_enable;
	logic                     cap_a, cap_b;
	logic [3:0]               sup;
	logic [95:0]              lit;
	logic [7:0]               ram [12];
	logic [7:0]               d, r;
	logic [7:0]               cases [5] = '{8'h8c, 8'h09, 8'h86, 8'h1f, 8'h2e};
	integer                   seed = 61776;
	int                       n_fail = 0;
	int                       n_tests = 0;

	always #2.5 mclk = ~mclk;

	ldc_drive_control ldc_drive_control_i (.mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req),
		.rd_data(rd_data), .timebase_tick(tb_tick), .subclock_tick(sc_tick),
		.watch_mode_flag(watch_mode_flag), .common_drive_outputs(com), .segment_drive_outputs(seg),
		.booster_cap_a(cap_a), .booster_cap_b(cap_b), .drive_supply_pins(sup), .divider_path_close(div_close),
		.ref_gen_disconnect(ref_disc), .panel_enable(panel_enable));
	ldc_panel_model ldc_panel_model_i (.com(com), .seg(seg), .lit(lit));

	// ==========================================================
	// Bus and compare helpers
	task automatic check(input logic [95:0] seen, input logic [95:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge mclk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus_req.rd <= 1'b0;
		@(negedge mclk);
		v = rd_data;
	endtask

	// ==========================================================
	// Expected pin levels
	function automatic logic [7:0] exp_com(logic [7:0] c, int sl, int ph);
		logic [7:0] v;
		for (int i = 0; i < 4; i++)
			v[i*2+:2] = (i == sl) ? (ph ? ldc_pkg::LVL_V0 : ldc_pkg::LVL_V3) :
				((c[3:2] == ldc_pkg::MODE_HALF || !ph) ? ldc_pkg::LVL_V1 : ldc_pkg::LVL_V2);
		return v;
	endfunction
	function automatic logic [143:0] exp_seg(logic [7:0] c, int sl, int ph);
		logic [143:0] v;
		logic         on;
		v = '0;
		for (int i = 0; i < 24; i++) begin
			on = ram[i/2][(i%2)*4+sl] && !c[4];
			v[48+i*4+sl] = on;
			v[i*2+:2] = on ? (ph ? ldc_pkg::LVL_V3 : ldc_pkg::LVL_V0) :
				(c[3:2] == ldc_pkg::MODE_HALF) ? (ph ? ldc_pkg::LVL_V0 : ldc_pkg::LVL_V3) :
				(ph ? ldc_pkg::LVL_V1 : ldc_pkg::LVL_V2);
		end
		return v;
	endfunction

	// ==========================================================
	// One display run: stop, load memory, start, tick through two frames
	task automatic run_case(input logic [7:0] c);
		int           n, u;
		logic [143:0] e;
		logic         live, p, t, s;
		wr(ldc_pkg::CTRL_ADDR, c & 8'hf3);
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		check({com, seg, panel_enable, cap_a, cap_b, sup}, '0, "stopped pins");
		for (int i = 0; i < 12; i++) begin
			ram[i] = 8'($random(seed));
			wr(8'h60 + 8'(i), ram[i]);
		end
		rd(8'h60 + 8'(c[3:0] % 12), d);
		check(d, ram[c[3:0] % 12], "memory readback");
		wr(ldc_pkg::CTRL_ADDR, c);
		rd(ldc_pkg::CTRL_ADDR, d);
		check(d, c, "ctrl readback");
		check({div_close, ref_disc}, {2{c[5]}}, "supply path");
		n = c[3:2] + 1;
		u = 1 << c[1:0];
		// Watch mode without the run bit keeps every drive, booster, supply and enable pin low
		live = !(watch_mode_flag && !c[6]);
		p = 1'b0;
		for (int k = 0; k <= 2 * n * u + 1; k++) begin
			repeat (2) @(posedge mclk);
			@(negedge mclk);
			e = live ? exp_seg(c, (k / u) % n, (k / u / n) % 2) : '0;
			check(com, live ? exp_com(c, (k / u) % n, (k / u / n) % 2) : 8'h00, "commons");
			check(seg, e[47:0], "segments");
			check(lit, e[143:48], "panel cells");
			check({panel_enable, sup}, live ? 5'h1f : 5'h00, "enable and supply");
			check({cap_a, cap_b}, live ? {p, !p} : 2'h0, "booster phases");
			@(posedge mclk);
			t = c[7] ? 1'($random(seed)) : 1'b1;
			s = c[7] ? 1'b1 : 1'($random(seed));
			tb_tick <= t;
			sc_tick <= s;
			p = p ^ (s & live);
			@(posedge mclk);
			tb_tick <= 1'b0;
			sc_tick <= 1'b0;
		end
	endtask

	task automatic report_and_stop();
		if (n_fail == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		#200000;
		n_fail++;
		report_and_stop();
	end

	initial begin
		repeat (4) @(posedge mclk);
		sys_rst <= 1'b0;
		@(negedge mclk);
		check({com, seg, panel_enable, cap_a, cap_b, sup}, '0, "reset pins");
		rd(ldc_pkg::CTRL_ADDR, d);
		check(d, ldc_pkg::CTRL_RESET, "reset ctrl");
		rd(8'h50, d);
		check(d, ldc_pkg::READ_ZERO, "unmapped read");
		wr(8'h73, 8'hff);
		rd(ldc_pkg::CTRL_ADDR, d);
		check(d, ldc_pkg::CTRL_RESET, "unmapped write");
		foreach (cases[i]) run_case(cases[i]);
		repeat (4) begin
			r = 8'($random(seed));
			if (r[3:2] == 2'h0) r[3] = 1'b1;
			run_case(r);
		end
		watch_mode_flag <= 1'b1;
		run_case(8'hcd);
		run_case(8'h8c);
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		check({com, seg, panel_enable, cap_a, cap_b, sup}, '0, "watch stop");
		watch_mode_flag <= 1'b0;
		report_and_stop();
	end
endmodule // tb_ldc_drive_control
